// *** rtl/fcss_host.sv ***
// Host controller that drives the flash command and status interface
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fcss_host #(
    parameter int ADDR_W = fcss_pkg::ADDR_W,
    parameter int DATA_W = fcss_pkg::DATA_W,
    parameter int BLOCK_LSB = fcss_pkg::BLOCK_LSB
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    output fcss_pkg::fcss_pins_t o_flash_ctl,
    output logic [ADDR_W-1:0] o_flash_addr,
    output logic [DATA_W-1:0] o_flash_dq,
    input wire logic [DATA_W-1:0] i_flash_dq
);
    import fcss_pkg::*;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_SETUP = 7'b0000010,
        ST_SECOND = 7'b0000100,
        ST_READ = 7'b0001000,
        ST_POLL = 7'b0010000,
        ST_CLEAR = 7'b0100000,
        ST_ARRAY = 7'b1000000
    } fcss_state_t;

    fcss_state_t state, next_state;
    logic [3:0] op, next_op;
    logic alt, next_alt, autoclr, next_autoclr, nowait, next_nowait;
    logic [ADDR_W-1:0] sw_addr, next_sw_addr, cur_addr, next_cur_addr;
    logic [DATA_W-1:0] sw_data, next_sw_data, cur_data, next_cur_data, rdata, next_rdata;
    logic [7:0] sr, next_sr;
    logic esusp, next_esusp, psusp, next_psusp, running, next_running, refused, next_refused;
    logic [ADDR_W-1:BLOCK_LSB] sblock, next_sblock;
    logic start, t_busy, t_strobe, t_done, wstate, rstate, same_blk;
    logic [7:0] code;
    logic [31:0] status_word, next_reg_rdata;
    fcss_pins_t next_pins;
    logic [ADDR_W-1:0] next_flash_addr;
    logic [DATA_W-1:0] next_flash_dq;

    fcss_cycle_timer #(.CYCLES(BUS_CYCLES)) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_start(start),
        .o_busy(t_busy),
        .o_strobe(t_strobe),
        .o_done(t_done)
    );

    function automatic logic op_allowed(input logic [3:0] o, input logic same);
        logic ok;
        ok = 1'b0;
        if (running) begin
            ok = (o == OP_READ_STATUS) || (o == OP_SUSPEND) || (o == OP_WAIT);
        end else if (psusp) begin
            ok = (o == OP_READ_STATUS) || (o == OP_READ_ID) || (o == OP_RESUME) || (o == OP_WAIT)
                || (o == OP_READ_ARRAY && !(esusp && same));
        end else if (esusp) begin
            ok = (o == OP_READ_STATUS) || (o == OP_READ_ID) || (o == OP_RESUME) || (o == OP_WAIT)
                || ((o == OP_READ_ARRAY || o == OP_PROGRAM) && !same);
        end else begin
            ok = (o <= OP_WAIT) && (o != OP_SUSPEND) && (o != OP_RESUME);
        end
        return ok;
    endfunction

    assign same_blk = (sw_addr[ADDR_W-1:BLOCK_LSB] == sblock);
    assign wstate = (state == ST_SETUP) || (state == ST_SECOND) || (state == ST_CLEAR) || (state == ST_ARRAY);
    assign rstate = (state == ST_READ) || (state == ST_POLL);

    always_comb begin
        next_state = state;
        next_op = op;
        next_alt = alt;
        next_autoclr = autoclr;
        next_nowait = nowait;
        next_sw_addr = sw_addr;
        next_sw_data = sw_data;
        next_cur_addr = cur_addr;
        next_cur_data = cur_data;
        next_rdata = rdata;
        next_sr = sr;
        next_esusp = esusp;
        next_psusp = psusp;
        next_running = running;
        next_refused = refused;
        next_sblock = sblock;
        if (i_reg_wr) begin
            case (i_reg_addr)
                REG_ADDR: next_sw_addr = i_reg_wdata[ADDR_W-1:0];
                REG_WDATA: next_sw_data = i_reg_wdata[DATA_W-1:0];
                REG_STATUS: begin
                    if (i_reg_wdata[STAT_REFUSED]) begin
                        next_refused = 1'b0;
                    end
                end
                REG_CTRL: begin
                    if (state == ST_IDLE && op_allowed(i_reg_wdata[CTRL_OP_LSB +: 4], same_blk)) begin
                        next_op = i_reg_wdata[CTRL_OP_LSB +: 4];
                        next_alt = i_reg_wdata[CTRL_ALT_BIT];
                        next_autoclr = i_reg_wdata[CTRL_AUTOCLR_BIT];
                        next_nowait = i_reg_wdata[CTRL_NOWAIT_BIT];
                        next_cur_addr = sw_addr;
                        next_cur_data = sw_data;
                        next_state = ST_SETUP;
                    end else begin
                        next_refused = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (t_done) begin
            case (state)
                ST_SETUP: begin
                    if (op == OP_PROGRAM || op == OP_ERASE) begin
                        next_state = ST_SECOND;
                    end else if (op == OP_READ_ARRAY || op == OP_READ_ID || op == OP_READ_STATUS) begin
                        next_state = ST_READ;
                    end else if (op == OP_RESUME && nowait) begin
                        next_running = 1'b1;
                        next_state = ST_IDLE;
                    end else if (op == OP_CLEAR) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_state = ST_POLL;
                    end
                end
                ST_SECOND: begin
                    if (op == OP_ERASE) begin
                        next_sblock = cur_addr[ADDR_W-1:BLOCK_LSB];
                    end
                    next_running = nowait;
                    next_state = nowait ? ST_IDLE : ST_POLL;
                end
                ST_READ: begin
                    next_rdata = i_flash_dq;
                    if (op == OP_READ_STATUS) begin
                        next_sr = i_flash_dq[7:0] & SR_MASK;
                    end
                    next_state = ST_IDLE;
                end
                ST_POLL: begin
                    next_sr = i_flash_dq[7:0] & SR_MASK;
                    next_rdata = i_flash_dq;
                    if (i_flash_dq[SR_READY]) begin
                        // Suspend flags trusted only once the machine reports ready
                        next_esusp = i_flash_dq[SR_ESUSP];
                        next_psusp = i_flash_dq[SR_PSUSP];
                        next_running = 1'b0;
                        next_state = (autoclr && op != OP_SUSPEND) ? ST_CLEAR : ST_IDLE;
                    end
                end
                ST_CLEAR: next_state = ST_ARRAY;
                ST_ARRAY: next_state = ST_IDLE;
                default: next_state = ST_IDLE;
            endcase
        end
    end

    assign start = (state == ST_IDLE) ? (next_state == ST_SETUP) : (t_done && next_state != ST_IDLE);

    always_comb begin
        case (state)
            ST_SETUP: begin
                case (op)
                    OP_READ_ARRAY: code = CMD_READ_ARRAY;
                    OP_READ_ID: code = CMD_READ_ID;
                    OP_CLEAR: code = CMD_CLEAR;
                    OP_PROGRAM: code = alt ? CMD_PROG_ALT : CMD_PROG;
                    OP_ERASE: code = CMD_ERASE;
                    OP_SUSPEND: code = CMD_SUSPEND;
                    OP_RESUME: code = CMD_RESUME;
                    default: code = CMD_READ_STATUS;
                endcase
            end
            ST_SECOND: code = CMD_CONFIRM;
            ST_CLEAR: code = CMD_CLEAR;
            default: code = CMD_READ_ARRAY;
        endcase
        next_flash_dq = (state == ST_SECOND && op == OP_PROGRAM) ? cur_data : {{(DATA_W-8){1'b0}}, code};
        next_flash_addr = (state == ST_SECOND || state == ST_READ) ? cur_addr : '0;
        // Chip select drops between operations, which lets a suspended device idle
        next_pins.ce_n = !t_busy;
        next_pins.we_n = !(wstate && t_strobe);
        next_pins.oe_n = !(rstate && t_strobe);
        next_pins.dq_oe = wstate && t_busy;
    end

    always_comb begin
        status_word = '0;
        status_word[7:0] = sr;
        status_word[STAT_BUSY] = (state != ST_IDLE);
        status_word[STAT_ESUSP] = esusp;
        status_word[STAT_PSUSP] = psusp;
        status_word[STAT_REFUSED] = refused;
        status_word[STAT_RUNNING] = running;
        if (sr[SR_READY]) begin
            status_word[STAT_SEQERR] = sr[SR_EFAIL] && sr[SR_PFAIL];
            status_word[STAT_EFAIL] = sr[SR_EFAIL] && !sr[SR_PFAIL];
            status_word[STAT_PFAIL] = sr[SR_PFAIL] && !sr[SR_EFAIL];
            status_word[STAT_VLOW] = sr[SR_VLOW];
            status_word[STAT_LOCK] = sr[SR_LOCK];
        end
        next_reg_rdata = '0;
        if (i_reg_rd) begin
            case (i_reg_addr)
                REG_CTRL: next_reg_rdata = {25'h0000000, nowait, autoclr, alt, op};
                REG_ADDR: next_reg_rdata[ADDR_W-1:0] = sw_addr;
                REG_WDATA: next_reg_rdata[DATA_W-1:0] = sw_data;
                REG_RDATA: next_reg_rdata[DATA_W-1:0] = rdata;
                REG_STATUS: next_reg_rdata = status_word;
                default: next_reg_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
            op <= OP_READ_ARRAY;
            alt <= 1'b0;
            autoclr <= 1'b0;
            nowait <= 1'b0;
            sw_addr <= '0;
            sw_data <= '0;
            cur_addr <= '0;
            cur_data <= '0;
            rdata <= '0;
            sr <= '0;
            esusp <= 1'b0;
            psusp <= 1'b0;
            running <= 1'b0;
            refused <= 1'b0;
            sblock <= '0;
            o_reg_rdata <= '0;
            o_flash_ctl <= PINS_IDLE;
            o_flash_addr <= '0;
            o_flash_dq <= '0;
        end else begin
            state <= next_state;
            op <= next_op;
            alt <= next_alt;
            autoclr <= next_autoclr;
            nowait <= next_nowait;
            sw_addr <= next_sw_addr;
            sw_data <= next_sw_data;
            cur_addr <= next_cur_addr;
            cur_data <= next_cur_data;
            rdata <= next_rdata;
            sr <= next_sr;
            esusp <= next_esusp;
            psusp <= next_psusp;
            running <= next_running;
            refused <= next_refused;
            sblock <= next_sblock;
            o_reg_rdata <= next_reg_rdata;
            o_flash_ctl <= next_pins;
            o_flash_addr <= next_flash_addr;
            o_flash_dq <= next_flash_dq;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_we_pulse;
        !o_flash_ctl.we_n [*3] ##1 o_flash_ctl.we_n;
    endsequence
    property p_we_width;
        $fell(o_flash_ctl.we_n) |-> s_we_pulse;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
    property p_prog_second;
        $rose(state == ST_SECOND) |-> $past(state == ST_SETUP) && $past(op == OP_PROGRAM || op == OP_ERASE);
    endproperty
    a_prog_second: assert property (p_prog_second) else $error("second write without setup");
    property p_confirm_code;
        (state == ST_SECOND && op == OP_ERASE && !o_flash_ctl.we_n) |-> o_flash_dq[7:0] == CMD_CONFIRM;
    endproperty
    a_confirm_code: assert property (p_confirm_code) else $error("erase confirm code wrong");
    property p_poll_busy;
        (state == ST_POLL && t_done && !i_flash_dq[SR_READY]) |=> state == ST_POLL && running == $past(running);
    endproperty
    a_poll_busy: assert property (p_poll_busy) else $error("busy status ended polling");
    property p_mask;
        $changed(sr) |-> !sr[0];
    endproperty
    a_mask: assert property (p_mask) else $error("reserved status bit kept");
    // Clear write spans exactly one bus cycle of five clocks
    sequence s_clear_then_array;
        (state == ST_CLEAR) [*5] ##1 (state == ST_ARRAY);
    endsequence
    property p_clear_after;
        (state == ST_POLL && t_done && i_flash_dq[SR_READY] && autoclr && op != OP_SUSPEND) |=> s_clear_then_array;
    endproperty
    a_clear_after: assert property (p_clear_after) else $error("status not cleared after completion");
    property p_array_code;
        (state == ST_ARRAY && !o_flash_ctl.we_n) |-> o_flash_dq[7:0] == CMD_READ_ARRAY;
    endproperty
    a_array_code: assert property (p_array_code) else $error("read array code wrong");
    property p_refuse;
        (i_reg_wr && i_reg_addr == REG_CTRL && esusp && !running
            && i_reg_wdata[CTRL_OP_LSB +: 4] == OP_ERASE) |=> refused && state == $past(state);
    endproperty
    a_refuse: assert property (p_refuse) else $error("erase accepted during suspend");
endmodule
`default_nettype wire

// *** include/fcss_pkg.sv ***
// Constants, types and command codes for the flash command and status host controller
package fcss_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int BUS_CYCLE_NS = 200;
    localparam int BUS_CYCLES = (BUS_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int BLOCK_LSB = 15;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic dq_oe;
    } fcss_pins_t;

    localparam fcss_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0};

    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR = 8'h50;
    localparam logic [7:0] CMD_PROG = 8'h40;
    localparam logic [7:0] CMD_PROG_ALT = 8'h10;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_RESUME = 8'hD0;

    localparam logic [3:0] OP_READ_ARRAY = 4'h0;
    localparam logic [3:0] OP_READ_ID = 4'h1;
    localparam logic [3:0] OP_READ_STATUS = 4'h2;
    localparam logic [3:0] OP_CLEAR = 4'h3;
    localparam logic [3:0] OP_PROGRAM = 4'h4;
    localparam logic [3:0] OP_ERASE = 4'h5;
    localparam logic [3:0] OP_SUSPEND = 4'h6;
    localparam logic [3:0] OP_RESUME = 4'h7;
    localparam logic [3:0] OP_WAIT = 4'h8;

    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_RDATA = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;

    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_ALT_BIT = 4;
    localparam int CTRL_AUTOCLR_BIT = 5;
    localparam int CTRL_NOWAIT_BIT = 6;

    localparam int STAT_BUSY = 8;
    localparam int STAT_ESUSP = 9;
    localparam int STAT_PSUSP = 10;
    localparam int STAT_REFUSED = 11;
    localparam int STAT_SEQERR = 12;
    localparam int STAT_EFAIL = 13;
    localparam int STAT_PFAIL = 14;
    localparam int STAT_VLOW = 15;
    localparam int STAT_LOCK = 16;
    localparam int STAT_RUNNING = 17;

    localparam int SR_READY = 7;
    localparam int SR_ESUSP = 6;
    localparam int SR_EFAIL = 5;
    localparam int SR_PFAIL = 4;
    localparam int SR_VLOW = 3;
    localparam int SR_PSUSP = 2;
    localparam int SR_LOCK = 1;
    localparam logic [7:0] SR_MASK = 8'hFE;
endpackage

// *** rtl/fcss_cycle_timer.sv ***
// Bus cycle timer: paces one flash read or write cycle
`timescale 1ns/1ps
`default_nettype none
module fcss_cycle_timer #(
    parameter int CYCLES = fcss_pkg::BUS_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_start,
    output logic o_busy,
    output logic o_strobe,
    output logic o_done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    localparam logic [CW-1:0] STROBE_END = CW'(CYCLES - 2);
    localparam logic [CW-1:0] ONE = CW'(1);
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic busy;
    logic next_busy;

    assign o_busy = busy;
    assign o_done = busy && (cnt == LAST);
    // Strobe sits inside the cycle so address and data settle before and hold after
    assign o_strobe = busy && (cnt >= ONE) && (cnt <= STROBE_END);

    always_comb begin
        next_cnt = cnt;
        next_busy = busy;
        if (i_start) begin
            next_cnt = '0;
            next_busy = 1'b1;
        end else if (o_done) begin
            next_busy = 1'b0;
        end else if (busy) begin
            next_cnt = cnt + ONE;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt <= '0;
            busy <= 1'b0;
        end else begin
            cnt <= next_cnt;
            busy <= next_busy;
        end
    end
endmodule
`default_nettype wire

// *** tb/fcss_flash_model.sv ***
// Behavioural model of the flash device on the far side of the host controller
`timescale 1ns/1ps
`default_nettype none
module fcss_flash_model #(
    parameter int PROG_T = 150,
    parameter int ERASE_T = 400,
    parameter logic [15:0] MFR_CODE = 16'h0001, // Arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h0002 // Arbitrary value
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire fcss_pkg::fcss_pins_t i_ctl,
    input wire logic [21:0] i_addr,
    input wire logic [15:0] i_dq,
    output logic [15:0] o_dq,
    input wire logic i_lock,
    input wire logic i_vpp_ok,
    input wire logic i_fail
);
    import fcss_pkg::*;
    logic [15:0] mem [0:255];
    logic [15:0] val, pdata;
    logic [15:0] last = 16'h5A5A;
    logic [21:0] paddr;
    logic [7:0] sr, c;
    logic [1:0] mode, pend, eblk;
    logic run, isprog, we_q, hit;
    int cnt, pcnt, ecnt;
    // Only four blocks of 64 words are kept
    function automatic logic [7:0] idx(input logic [21:0] a);
        return {a[16:15], a[5:0]};
    endfunction
    always_comb begin
        case (mode)
            2'h0: val = mem[idx(i_addr)];
            2'h1: val = i_addr[0] ? DEV_CODE : MFR_CODE;
            default: val = {8'h00, sr};
        endcase
    end
    // Released bus shows the inverse of the last value so stale data cannot pass
    assign o_dq = (!i_ctl.ce_n && !i_ctl.oe_n) ? val : ~last;
    always @(posedge i_sys_clk) begin
        we_q <= i_ctl.we_n;
        if (!i_ctl.ce_n && !i_ctl.oe_n) begin
            last <= val;
        end
        hit = i_lock && i_addr[16:15] == 2'h3;
        c = i_dq[7:0];
        if (i_rst) begin
            {sr, mode, pend, run} = {8'h80, 2'h0, 2'h0, 1'b0};
            foreach (mem[i]) begin
                mem[i] = 16'hFFFF;
            end
        end else if (i_ctl.we_n && !we_q && !i_ctl.ce_n) begin
            if (pend == 2'h1) begin
                pend = 2'h0;
                if (hit) sr[1] = 1'b1;
                else if (!i_vpp_ok) sr[4:3] = 2'h3;
                else {run, isprog, sr[7], cnt, paddr, pdata} = {3'b110, PROG_T, i_addr, i_dq};
            end else if (pend == 2'h2) begin
                pend = 2'h0;
                if (c != CMD_CONFIRM) sr[5:4] = 2'h3;
                else if (hit) sr[1] = 1'b1;
                else if (!i_vpp_ok) {sr[5], sr[3]} = 2'h3;
                else {run, isprog, sr[7], cnt, eblk} = {3'b100, ERASE_T, i_addr[16:15]};
            end else begin
                case (c)
                    CMD_READ_ARRAY: mode = 2'h0;
                    CMD_READ_ID: mode = 2'h1;
                    CMD_READ_STATUS: mode = 2'h2;
                    CMD_CLEAR: {sr[5:3], sr[1]} = 4'h0;
                    CMD_PROG, CMD_PROG_ALT: {pend, mode} = 4'h6;
                    CMD_ERASE: if (sr[6]) sr[5:4] = 2'h3;
                    else {pend, mode} = 4'hA;
                    CMD_SUSPEND: if (run) begin
                        {run, sr[7], mode} = 4'h6;
                        if (isprog) {sr[2], pcnt} = {1'b1, cnt};
                        else {sr[6], ecnt} = {1'b1, cnt};
                    end
                    CMD_RESUME: if (sr[2]) {sr[2], sr[7], run, isprog, mode, cnt} = {6'b001110, pcnt};
                    else if (sr[6]) {sr[6], sr[7], run, isprog, mode, cnt} = {6'b001010, ecnt};
                    default: sr[5:4] = 2'h3;
                endcase
            end
        end else if (run) begin
            cnt = cnt - 1;
            if (cnt == 0) begin
                {run, sr[7]} = 2'b01;
                if (!i_vpp_ok) sr = sr | (isprog ? 8'h18 : 8'h28);
                else if (i_fail) sr = sr | (isprog ? 8'h10 : 8'h20);
                else if (isprog) mem[idx(paddr)] = mem[idx(paddr)] & pdata;
                else for (int i = 0; i < 64; i++) mem[{eblk, i[5:0]}] = 16'hFFFF;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/tb_fcss_host.sv ***
// Self-checking testbench for the flash command and status host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; \
$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_fcss_host;
    import fcss_pkg::*;
    localparam logic [15:0] MFR = 16'h00A5; // Arbitrary value
    localparam logic [15:0] DEV = 16'h5A3C; // Arbitrary value
    logic i_sys_clk, i_rst, i_reg_wr, i_reg_rd, lock, vpp_ok, fail;
    logic [3:0] i_reg_addr;
    logic [31:0] i_reg_wdata, o_reg_rdata, d;
    fcss_pins_t o_flash_ctl;
    logic [ADDR_W-1:0] o_flash_addr;
    logic [DATA_W-1:0] o_flash_dq, i_flash_dq;
    int n_mismatch = 0;
    int cmp_count = 0;
    fcss_host u_fcss_host (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_flash_ctl(o_flash_ctl),
        .o_flash_addr(o_flash_addr), .o_flash_dq(o_flash_dq), .i_flash_dq(i_flash_dq));
    fcss_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_fcss_flash_model (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_ctl(o_flash_ctl), .i_addr(o_flash_addr), .i_dq(o_flash_dq), .o_dq(i_flash_dq), .i_lock(lock),
        .i_vpp_ok(vpp_ok), .i_fail(fail));
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_wdata <= v;
        i_reg_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_sys_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_sys_clk);
        d = o_reg_rdata;
    endtask
    // Bounded poll: a stuck op shows up as a busy bit in the next status check
    task automatic op(input logic [6:0] ctrl, input logic [21:0] a, input logic [15:0] v);
        int n;
        wr(REG_ADDR, {10'h0, a});
        wr(REG_WDATA, {16'h0, v});
        wr(REG_CTRL, {25'h0, ctrl});
        n = 0;
        do begin
            rd(REG_STATUS);
            n++;
        end while (d[STAT_BUSY] !== 1'b0 && n < 2000);
    endtask
    task automatic stat(input logic [16:0] ex);
        rd(REG_STATUS);
        `CHK("status", {1'b0, ex}, d[17:0])
    endtask
    task automatic rdat(input logic [15:0] ex);
        rd(REG_RDATA);
        `CHK("read data", {16'h0, ex}, d)
    endtask
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        repeat (60000) @(posedge i_sys_clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        {i_rst, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata, lock, vpp_ok, fail} = {3'b100, 4'h0, 32'h0, 3'b010};
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        stat(17'h0);
        rd(4'hF);
        `CHK("unmapped read", 32'h0, d)
        op(7'h01, 22'h0, 16'h0);
        rdat(MFR);
        op(7'h01, 22'h1, 16'h0);
        rdat(DEV);
        op(7'h04, 22'h8, 16'h0F0F);
        stat(17'h00080);
        op(7'h14, 22'h08010, 16'h0F0F);
        op(7'h00, 22'h08010, 16'h0);
        rdat(16'h0F0F);
        op(7'h02, 22'h0, 16'h0);
        rdat(16'h0080);
        fail <= 1'b1;
        op(7'h04, 22'h20, 16'h1111);
        stat(17'h04090);
        fail <= 1'b0;
        op(7'h04, 22'h21, 16'h2222);
        stat(17'h04090);
        op(7'h03, 22'h0, 16'h0);
        op(7'h08, 22'h0, 16'h0);
        stat(17'h00080);
        vpp_ok <= 1'b0;
        op(7'h04, 22'h22, 16'h3333);
        stat(17'h0C098);
        {vpp_ok, lock} <= 2'b11;
        op(7'h03, 22'h0, 16'h0);
        op(7'h04, 22'h18000, 16'h4444);
        stat(17'h10082);
        lock <= 1'b0;
        op(7'h03, 22'h0, 16'h0);
        op(7'h45, 22'h08000, 16'h0);
        rd(REG_STATUS);
        `CHK("running", 1'b1, d[STAT_RUNNING])
        op(7'h06, 22'h0, 16'h0);
        stat(17'h002C0);
        op(7'h00, 22'h08010, 16'h0);
        stat(17'h00AC0);
        wr(REG_STATUS, 32'h800);
        op(7'h05, 22'h0, 16'h0);
        stat(17'h00AC0);
        wr(REG_STATUS, 32'h800);
        op(7'h44, 22'h30, 16'h1234);
        op(7'h06, 22'h0, 16'h0);
        stat(17'h006C4);
        op(7'h07, 22'h0, 16'h0);
        stat(17'h002C0);
        op(7'h00, 22'h30, 16'h0);
        rdat(16'h1234);
        op(7'h07, 22'h0, 16'h0);
        stat(17'h00080);
        op(7'h00, 22'h08010, 16'h0);
        rdat(16'hFFFF);
        fail <= 1'b1;
        op(7'h24, 22'h40, 16'h5555);
        stat(17'h04090);
        fail <= 1'b0;
        op(7'h08, 22'h0, 16'h0);
        stat(17'h00080);
        summarize();
    end
endmodule
`default_nettype wire
